// ### ulrc_chk_sva.sv
// Property checker for ulrc_top: mode controls, end-of-packet kinds, receive commands.
// Assumes it is bound to ulrc_top and sees only that module's ports.
`timescale 1ns/100ps
module ulrc_chk (
    // Clock, reset and register port
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input wire logic [3:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    // Link and front end
    input wire logic [7:0]          link_data,
    input wire logic                rxcmd_valid,
    input wire logic [7:0]          rxcmd_byte,
    input wire logic                a_device_supply_valid,
    input wire logic                id_pin,
    // Transmitter and static controls
    input wire logic                tx_start,
    input wire logic                sync_auto,
    input wire logic                nrzi_stuff_en,
    input wire logic                eop_strobe,
    input wire ulrc_pkg::ulrc_eop_t eop_kind,
    input wire logic [1:0]          operating_mode_field,
    input wire logic                id_sense_pullup_enable,
    input wire logic                six_pin_serial_active,
    input wire logic                three_pin_serial_active
);
    logic rtx_r;
    ////////////////////////////////////////////////////////////////////////////
    // Marks a transmit launched in chirp/resume mode until its stop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            rtx_r <= 1'b0;
        else if (tx_start && operating_mode_field == 2'h2)
            rtx_r <= 1'b1;
        else if (eop_strobe)
            rtx_r <= 1'b0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Mode 11b held long enough for the lagging controls
    sequence nosync_mode;
        (operating_mode_field == 2'h3) [*2];
    endsequence
    sequence stop_nosync;
        eop_strobe && operating_mode_field == 2'h3;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    auto_off_a: assert property (nosync_mode |-> !sync_auto)
        else $error("sync generation left on");
    coding_on_a: assert property (nosync_mode |-> nrzi_stuff_en)
        else $error("coding off in mode 11b");
    nostuff_eop_a: assert property (stop_nosync ##0 link_data == 8'hfe |-> eop_kind == ulrc_pkg::EOP_NOSTUFF)
        else $error("wrong end kind for fe");
    no_eop_a: assert property (stop_nosync ##0 link_data == 8'h00 |-> eop_kind == ulrc_pkg::EOP_NONE)
        else $error("end sent for 00");
    long_eop_a: assert property (stop_nosync ##0 eop_kind == ulrc_pkg::EOP_LONG |-> link_data != 8'h00)
        else $error("long end on empty stop");
    resume_eop_a: assert property (eop_strobe && rtx_r |-> eop_kind inside {ulrc_pkg::EOP_RESUME, ulrc_pkg::EOP_NONE})
        else $error("wrong end after resume");
    quiet_resume_a: assert property ($rose(rxcmd_valid) |-> !rtx_r)
        else $error("receive command during resume");
    vbus_report_a: assert property ($rose(a_device_supply_valid) |-> ##[1:60] rxcmd_valid && rxcmd_byte[3:2] == 2'h3)
        else $error("supply change not reported");
    id_report_a: assert property ($changed(id_pin) && id_sense_pullup_enable
        |-> ##[1:60] rxcmd_valid && rxcmd_byte[6] == id_pin)
        else $error("id change not reported");
    serial_sel_a: assert property (reg_wr && reg_addr == ulrc_pkg::OFS_IFACE |-> ##2 six_pin_serial_active == $past(reg_wdata[0], 2)
        && three_pin_serial_active == ($past(reg_wdata[1], 2) && !$past(reg_wdata[0], 2)))
        else $error("serial mode wrong");
endmodule : ulrc_chk

// ### ulrc_link_model.sv
// Link controller model: free-running link clock and NOPID packets.
// Assumes its owner calls send from one procedural thread at a time.
`timescale 1ns/100ps
module ulrc_link_model (
    // Link pins
    output logic       link_clk,
    output logic [7:0] link_data,
    output logic       link_stp
);
    // Idle bus is driven low by the link
    initial begin
        link_clk = 1'b0;
        link_data = 8'h00;
        link_stp = 1'b0;
    end
    // Interface clock runs free, 80 ns period
    always #40 link_clk = ~link_clk;
    // Command, PID, then stop with its data byte; changes mid-period
    task automatic send(input logic [7:0] pid, input logic [7:0] last);
        @(negedge link_clk) link_data = 8'h40;
        @(negedge link_clk) link_data = pid;
        @(negedge link_clk) link_stp = 1'b1;
        link_data = last;
        @(negedge link_clk) link_stp = 1'b0;
        link_data = 8'h00;
    endtask : send
endmodule : ulrc_link_model

// ### ulrc_pkg.sv
// Constants and types shared by the ULPI resume / OTG / serial-mode block.
// Assumes an 8-bit register port with three word offsets and an 8-bit link data bus.
package ulrc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_IFACE  = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;

    // Control register fields
    localparam int CTRL_OPERATING_MODE_FIELD_LSB = 0;
    localparam int CTRL_XSEL_LSB   = 2;
    localparam int CTRL_TERM_BIT   = 4;
    localparam int CTRL_AWAKE_BIT  = 5;
    localparam int CTRL_IDPU_BIT   = 6;
    localparam int CTRL_HOST_BIT   = 7;

    // Interface control fields
    localparam int IFACE_SIX_BIT   = 0;
    localparam int IFACE_THREE_BIT = 1;

    // Comparator vector positions
    localparam int CMP_AVLD_BIT = 0;
    localparam int CMP_SVLD_BIT = 1;
    localparam int CMP_SEND_BIT = 2;
    localparam int CMP_ID_BIT   = 3;

    // Values after reset
    localparam logic [7:0] CTRL_RESET  = 8'h19;
    localparam logic [1:0] IFACE_RESET = 2'h0;

    // Operating mode encodings
    localparam logic [1:0] OPM_NORMAL  = 2'h0;
    localparam logic [1:0] OPM_NODRIVE = 2'h1;
    localparam logic [1:0] OPM_CHIRP   = 2'h2;
    localparam logic [1:0] OPM_NOSYNC  = 2'h3;

    // Link data patterns
    localparam logic [1:0] TXCMD_PREFIX = 2'h1;
    localparam logic [7:0] DAT_NOSTUFF  = 8'hfe;
    localparam logic [7:0] DAT_NOEOP    = 8'h00;
    localparam logic [7:0] PID_SOF      = 8'ha5;
    localparam logic [1:0] LS_K         = 2'h1;

    // Synchroniser depth for pins and link clock
    localparam int SYNC_DEPTH = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Enumerations
    typedef enum logic [2:0] {
        EOP_NONE,
        EOP_NORMAL,
        EOP_NOSTUFF,
        EOP_LONG,
        EOP_RESUME
    } ulrc_eop_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_PID,
        TX_DATA
    } ulrc_tx_t;

endpackage : ulrc_pkg

// ### ulrc_top.sv
// Device-side ULPI logic: resume EOP, no-auto-SYNC/EOP mode, OTG change reports, serial modes.
// Assumes link and analog inputs are asynchronous to clk_sys and are sampled by it.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/100ps

module ulrc_top (
    // System clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Link side; inputs asynchronous to clk_sys, receive command outputs registered on it
    input  wire logic        link_clk,
    input  wire logic [7:0]  link_data,
    input  wire logic        link_stp,
    output logic             rxcmd_valid,
    output logic      [7:0]  rxcmd_byte,
    // Analog front end, asynchronous
    input  wire logic [1:0]  line_state_field,
    input  wire logic        a_device_supply_valid,
    input  wire logic        session_valid_indication,
    input  wire logic        session_end_indication,
    input  wire logic        id_pin,
    // Transmitter controls
    output logic             tx_start,
    output logic             sync_auto,
    output logic             nrzi_stuff_en,
    output logic             eop_strobe,
    output ulrc_pkg::ulrc_eop_t eop_kind,
    // Static controls
    output logic      [1:0]  operating_mode_field,
    output logic      [1:0]  transceiver_speed_select,
    output logic             termination_select,
    output logic             low_power_exit_bit,
    output logic             id_sense_pullup_enable,
    output logic             six_pin_serial_active,
    output logic             three_pin_serial_active
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0]                                  ctrl;
        logic [1:0]                                  iface;
        logic [7:0]                                  rd_data;
        logic [ulrc_pkg::SYNC_DEPTH-1:0]             lclk_sy;
        logic [ulrc_pkg::SYNC_DEPTH-1:0]             stp_sy;
        logic [ulrc_pkg::SYNC_DEPTH-1:0][7:0]        data_sy;
        logic [ulrc_pkg::SYNC_DEPTH-1:0][3:0]        cmp_sy;
        logic [ulrc_pkg::SYNC_DEPTH-1:0][1:0]        ls_sy;
        logic                                        lclk_q;
        logic [3:0]                                  cmp_q;
        logic [1:0]                                  ls_q;
        logic                                        pend;
        logic                                        rx_valid;
        logic [7:0]                                  rx_byte;
        ulrc_pkg::ulrc_tx_t                          tx_st;
        logic                                        sof;
        logic                                        resume_drv;
        logic                                        eop_stb;
        ulrc_pkg::ulrc_eop_t                         eop_kind;
        logic                                        tx_start;
        logic                                        sync_auto;
        logic                                        enc_en;
        logic                                        six;
        logic                                        three;
    } ulrc_state_t;

    ulrc_state_t st_r;
    ulrc_state_t st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    function automatic logic [1:0] vbus_code(input logic [3:0] cmp);
        if (cmp[ulrc_pkg::CMP_AVLD_BIT]) begin
            vbus_code = 2'h3;
        end else if (cmp[ulrc_pkg::CMP_SVLD_BIT]) begin
            vbus_code = 2'h2;
        end else if (!cmp[ulrc_pkg::CMP_SEND_BIT]) begin
            vbus_code = 2'h1;
        end else begin
            vbus_code = 2'h0;
        end
    endfunction : vbus_code

    // Filtered value: a change counts once the last two stages agree
    function automatic logic [3:0] settle4(input logic [3:0] s1, input logic [3:0] s2,
                                           input logic [3:0] held);
        settle4 = (s1 == s2) ? s2 : held;
    endfunction : settle4

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic       lclk_f;
        logic       ledge;
        logic [3:0] cmp_f;
        logic [3:0] cmp_ch;
        logic [1:0] ls_f;
        logic [7:0] dat;
        logic       stp;
        logic       change;
        logic       busy;
        logic [1:0] opm;
        lclk_f = 1'b0;
        ledge  = 1'b0;
        cmp_f  = 4'h0;
        cmp_ch = 4'h0;
        ls_f   = 2'h0;
        dat    = 8'h00;
        stp    = 1'b0;
        change = 1'b0;
        busy   = 1'b0;
        opm    = 2'h0;
        st_nxt = st_r;

        // Synchronisers: stage 0 feeds only stage 1
        st_nxt.lclk_sy = {st_r.lclk_sy[1:0], link_clk};
        st_nxt.stp_sy  = {st_r.stp_sy[1:0], link_stp};
        st_nxt.data_sy = {st_r.data_sy[1:0], link_data};
        st_nxt.ls_sy   = {st_r.ls_sy[1:0], line_state_field};
        st_nxt.cmp_sy  = {st_r.cmp_sy[1:0],
                          {id_pin, session_end_indication, session_valid_indication, a_device_supply_valid}};

        lclk_f = (st_r.lclk_sy[1] == st_r.lclk_sy[2]) ? st_r.lclk_sy[2] : st_r.lclk_q;
        ledge  = lclk_f & ~st_r.lclk_q;
        st_nxt.lclk_q = lclk_f;
        dat = st_r.data_sy[2];
        stp = st_r.stp_sy[2];
        opm = st_r.ctrl[ulrc_pkg::CTRL_OPERATING_MODE_FIELD_LSB +: 2];

        // Comparator and ID tracking
        cmp_f = settle4(st_r.cmp_sy[1], st_r.cmp_sy[2], st_r.cmp_q);
        ls_f  = (st_r.ls_sy[1] == st_r.ls_sy[2]) ? st_r.ls_sy[2] : st_r.ls_q;
        st_nxt.cmp_q = cmp_f;
        st_nxt.ls_q  = ls_f;
        cmp_ch = cmp_f ^ st_r.cmp_q;
        if (!st_r.ctrl[ulrc_pkg::CTRL_IDPU_BIT]) begin
            cmp_ch[ulrc_pkg::CMP_ID_BIT] = 1'b0;
        end
        change = (|cmp_ch) | (ls_f != st_r.ls_q);

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ulrc_pkg::OFS_CTRL: begin
                    st_nxt.ctrl = reg_wdata;
                end
                ulrc_pkg::OFS_IFACE: begin
                    st_nxt.iface = reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle
        st_nxt.rd_data = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ulrc_pkg::OFS_CTRL:   st_nxt.rd_data = st_r.ctrl;
                ulrc_pkg::OFS_IFACE:  st_nxt.rd_data = {6'h00, st_r.iface};
                ulrc_pkg::OFS_STATUS: st_nxt.rd_data = {st_r.resume_drv, st_r.tx_st != ulrc_pkg::TX_IDLE,
                                                        st_r.ls_q, st_r.cmp_q};
                default:              st_nxt.rd_data = 8'h00;
            endcase
        end

        // Serial mode select; six-pin wins if both enables are set
        st_nxt.six   = st_r.iface[ulrc_pkg::IFACE_SIX_BIT];
        st_nxt.three = st_r.iface[ulrc_pkg::IFACE_THREE_BIT] & ~st_r.iface[ulrc_pkg::IFACE_SIX_BIT];

        // Encoder controls follow the operating mode
        st_nxt.sync_auto = (opm != ulrc_pkg::OPM_NOSYNC);
        st_nxt.enc_en    = (opm != ulrc_pkg::OPM_CHIRP);

        // One-cycle strobes
        st_nxt.tx_start = 1'b0;
        st_nxt.eop_stb  = 1'b0;

        // Transmit sequencing on link clock edges
        busy = (st_r.tx_st != ulrc_pkg::TX_IDLE);
        if (ledge) begin
            case (st_r.tx_st)
                ulrc_pkg::TX_IDLE: begin
                    if (dat[7:6] == ulrc_pkg::TXCMD_PREFIX) begin
                        st_nxt.tx_start   = 1'b1;
                        st_nxt.sof        = 1'b0;
                        st_nxt.resume_drv = (opm == ulrc_pkg::OPM_CHIRP);
                        st_nxt.tx_st      = (opm == ulrc_pkg::OPM_NOSYNC) ? ulrc_pkg::TX_PID : ulrc_pkg::TX_DATA;
                        busy              = 1'b1;
                    end
                end
                ulrc_pkg::TX_PID, ulrc_pkg::TX_DATA: begin
                    if (stp) begin
                        st_nxt.eop_stb    = 1'b1;
                        st_nxt.tx_st      = ulrc_pkg::TX_IDLE;
                        st_nxt.resume_drv = 1'b0;
                        if (st_r.resume_drv) begin
                            st_nxt.eop_kind = st_r.ctrl[ulrc_pkg::CTRL_HOST_BIT] ?
                                              ulrc_pkg::EOP_RESUME : ulrc_pkg::EOP_NONE;
                        end else if (opm == ulrc_pkg::OPM_NOSYNC) begin
                            if (dat == ulrc_pkg::DAT_NOEOP) begin
                                st_nxt.eop_kind = ulrc_pkg::EOP_NONE;
                            end else if (dat == ulrc_pkg::DAT_NOSTUFF) begin
                                st_nxt.eop_kind = ulrc_pkg::EOP_NOSTUFF;
                            end else if (st_r.sof) begin
                                st_nxt.eop_kind = ulrc_pkg::EOP_LONG;
                            end else begin
                                st_nxt.eop_kind = ulrc_pkg::EOP_NONE;
                            end
                        end else begin
                            st_nxt.eop_kind = st_r.sof ? ulrc_pkg::EOP_LONG : ulrc_pkg::EOP_NORMAL;
                        end
                    end else if (st_r.tx_st == ulrc_pkg::TX_PID) begin
                        st_nxt.sof   = (dat == ulrc_pkg::PID_SOF);
                        st_nxt.tx_st = ulrc_pkg::TX_DATA;
                    end
                end
                default: begin
                    st_nxt.tx_st = ulrc_pkg::TX_IDLE;
                end
            endcase
        end

        // Receive commands: held pending while busy, issued for one link clock
        if (ledge) begin
            st_nxt.rx_valid = 1'b0;
            if ((st_r.pend | change) && !busy) begin
                st_nxt.rx_valid = 1'b1;
                st_nxt.rx_byte  = {1'b0, cmp_f[ulrc_pkg::CMP_ID_BIT], 2'h0, vbus_code(cmp_f), ls_f};
                st_nxt.pend     = 1'b0;
            end else begin
                st_nxt.pend = st_r.pend | change;
            end
        end else begin
            st_nxt.pend = st_r.pend | change;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r          <= '0;
            st_r.ctrl     <= ulrc_pkg::CTRL_RESET;
            st_r.iface    <= ulrc_pkg::IFACE_RESET;
            st_r.tx_st    <= ulrc_pkg::TX_IDLE;
            st_r.eop_kind <= ulrc_pkg::EOP_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign reg_rdata                = st_r.rd_data;
    assign rxcmd_valid              = st_r.rx_valid;
    assign rxcmd_byte               = st_r.rx_byte;
    assign tx_start                 = st_r.tx_start;
    assign sync_auto                = st_r.sync_auto;
    assign nrzi_stuff_en            = st_r.enc_en;
    assign eop_strobe               = st_r.eop_stb;
    assign eop_kind                 = st_r.eop_kind;
    assign operating_mode_field     = st_r.ctrl[ulrc_pkg::CTRL_OPERATING_MODE_FIELD_LSB +: 2];
    assign transceiver_speed_select = st_r.ctrl[ulrc_pkg::CTRL_XSEL_LSB +: 2];
    assign termination_select       = st_r.ctrl[ulrc_pkg::CTRL_TERM_BIT];
    assign low_power_exit_bit       = st_r.ctrl[ulrc_pkg::CTRL_AWAKE_BIT];
    assign id_sense_pullup_enable   = st_r.ctrl[ulrc_pkg::CTRL_IDPU_BIT];
    assign six_pin_serial_active    = st_r.six;
    assign three_pin_serial_active  = st_r.three;

endmodule : ulrc_top

// ### ulrc_top_tb.sv
// Self-checking bench for ulrc_top with a link controller model.
// Assumes ulrc_link_model drives the link pins and ulrc_chk is bound below.
`timescale 1ns/100ps
module ulrc_top_tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr, reg_rd, link_clk, link_stp, rxcmd_valid;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, link_data, rxcmd_byte;
    logic [1:0] line_state_field, operating_mode_field, transceiver_speed_select;
    logic a_device_supply_valid, session_valid_indication, session_end_indication, id_pin;
    logic tx_start, sync_auto, nrzi_stuff_en, eop_strobe, termination_select, low_power_exit_bit;
    logic id_sense_pullup_enable, six_pin_serial_active, three_pin_serial_active, rx_q = 1'b0;
    logic [7:0] rx_b = 8'h00;
    ulrc_pkg::ulrc_eop_t eop_kind, kind_seen;
    int err_count = 0, num_checks = 0, rx_cnt = 0, tx_cnt = 0;
    always #2.5 clk_sys = ~clk_sys;
    ulrc_link_model lnk (.link_clk, .link_data, .link_stp);
    ulrc_top dut (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_clk, .link_data,
        .link_stp, .rxcmd_valid, .rxcmd_byte, .line_state_field, .a_device_supply_valid, .session_valid_indication,
        .session_end_indication, .id_pin, .tx_start, .sync_auto, .nrzi_stuff_en, .eop_strobe, .eop_kind,
        .operating_mode_field, .transceiver_speed_select, .termination_select, .low_power_exit_bit,
        .id_sense_pullup_enable, .six_pin_serial_active, .three_pin_serial_active);
    // Event counters and last end kind
    always @(posedge clk_sys) begin
        rx_q <= rxcmd_valid;
        rx_b <= rxcmd_byte;
        // A command issued right behind another keeps valid high, so a new byte counts too
        if (rxcmd_valid && (!rx_q || rxcmd_byte !== rx_b)) rx_cnt++;
        if (tx_start) tx_cnt++;
        if (eop_strobe) kind_seen = eop_kind;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask : rd
    task automatic wait_rx(input int n);
        for (int i = 0; i < 80 && rx_cnt == n; i++) @(posedge clk_sys);
        chk("rxcmd issued", 8'(rx_cnt != n), 8'h01);
        @(negedge clk_sys);
    endtask : wait_rx
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] v;
        rd(ulrc_pkg::OFS_CTRL, v);
        chk("ctrl reset", v, ulrc_pkg::CTRL_RESET);
        wr(ulrc_pkg::OFS_STATUS, 8'hff);
        wr(4'h3, 8'hff);
        rd(4'h3, v);
        chk("unmapped", v, 8'h00);
        rd(ulrc_pkg::OFS_STATUS, v);
        chk("status idle", v, 8'h00);
        chk("speed term", {3'h0, operating_mode_field, transceiver_speed_select, termination_select}, 8'h0d);
    endtask : t_regs
    task automatic t_send(input logic [7:0] ctrl, pid, last, input ulrc_pkg::ulrc_eop_t k);
        int n;
        wr(ulrc_pkg::OFS_CTRL, ctrl);
        n = tx_cnt;
        lnk.send(pid, last);
        repeat (4) @(posedge clk_sys);
        chk("tx start", 8'(tx_cnt - n), 8'h01);
        chk("eop kind", 8'(kind_seen), 8'(k));
    endtask : t_send
    task automatic t_nosync();
        t_send(8'h03, 8'hc3, 8'hfe, ulrc_pkg::EOP_NOSTUFF);
        chk("sync auto", {7'h0, sync_auto}, 8'h00);
        chk("coding", {7'h0, nrzi_stuff_en}, 8'h01);
        t_send(8'h03, 8'hc3, 8'h00, ulrc_pkg::EOP_NONE);
        t_send(8'h03, 8'ha5, 8'h11, ulrc_pkg::EOP_LONG);
        t_send(8'h03, 8'hc3, 8'h11, ulrc_pkg::EOP_NONE);
        t_send(8'h00, 8'ha5, 8'h11, ulrc_pkg::EOP_NORMAL);
        chk("sync auto", {7'h0, sync_auto}, 8'h01);
    endtask : t_nosync
    task automatic t_resume();
        int n;
        wr(ulrc_pkg::OFS_CTRL, 8'ha2);
        chk("coding", {7'h0, nrzi_stuff_en}, 8'h00);
        chk("awake", {7'h0, low_power_exit_bit}, 8'h01);
        n = rx_cnt;
        fork
            lnk.send(8'h00, 8'h00);
            begin
                wait (tx_start);
                @(posedge clk_sys) line_state_field <= ulrc_pkg::LS_K;
                repeat (18) @(posedge clk_sys);
                chk("quiet resume", 8'(rx_cnt - n), 8'h00);
            end
        join
        wait_rx(n);
        chk("pending line", {6'h0, rxcmd_byte[1:0]}, {6'h0, ulrc_pkg::LS_K});
        chk("eop kind", 8'(kind_seen), 8'(ulrc_pkg::EOP_RESUME));
        t_send(8'h22, 8'h00, 8'h00, ulrc_pkg::EOP_NONE);
        n = rx_cnt;
        @(posedge clk_sys) line_state_field <= 2'h0;
        wait_rx(n);
        chk("line back", {6'h0, rxcmd_byte[1:0]}, 8'h00);
        wr(ulrc_pkg::OFS_CTRL, 8'h00);
    endtask : t_resume
    task automatic t_otg();
        logic [4:0] tbl [4] = '{5'b110_11, 5'b010_10, 5'b000_01, 5'b001_00};
        logic [7:0] v;
        int n;
        foreach (tbl[i]) begin
            n = rx_cnt;
            @(posedge clk_sys) {a_device_supply_valid, session_valid_indication, session_end_indication} <= tbl[i][4:2];
            wait_rx(n);
            chk("vbus code", {6'h0, rxcmd_byte[3:2]}, {6'h0, tbl[i][1:0]});
            rd(ulrc_pkg::OFS_STATUS, v);
            chk("status cmp", {5'h0, v[2:0]}, {5'h0, tbl[i][2], tbl[i][3], tbl[i][4]});
        end
        n = rx_cnt;
        @(posedge clk_sys) id_pin <= 1'b1;
        repeat (60) @(posedge clk_sys);
        chk("id ignored", 8'(rx_cnt - n), 8'h00);
        wr(ulrc_pkg::OFS_CTRL, 8'h40);
        chk("id_sense_pullup_enable", {7'h0, id_sense_pullup_enable}, 8'h01);
        repeat (40) @(posedge clk_sys);
        n = rx_cnt;
        @(posedge clk_sys) id_pin <= 1'b0;
        wait_rx(n);
        chk("id report", {7'h0, rxcmd_byte[6]}, 8'h00);
    endtask : t_otg
    task automatic t_serial();
        logic [1:0] d;
        for (int i = 1; i <= 4; i++) begin
            d = 2'(i);
            wr(ulrc_pkg::OFS_IFACE, {6'h0, d});
            chk("serial", {6'h0, six_pin_serial_active, three_pin_serial_active}, {6'h0, d[0], d[1] & ~d[0]});
        end
    endtask : t_serial
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, line_state_field, id_pin} = '0;
        {a_device_supply_valid, session_valid_indication, session_end_indication} = '0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs();
        t_nosync();
        t_resume();
        t_otg();
        t_serial();
        give_verdict();
    end
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : ulrc_top_tb
bind ulrc_top ulrc_chk u_chk (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .link_data, .rxcmd_valid,
    .rxcmd_byte, .a_device_supply_valid, .id_pin, .tx_start, .sync_auto, .nrzi_stuff_en, .eop_strobe, .eop_kind,
    .operating_mode_field, .id_sense_pullup_enable, .six_pin_serial_active, .three_pin_serial_active);
